// ---- design/fbg_defs.svh ----
// Constants for the flash bus glue device front end
`ifndef FBG_DEFS_SVH
`define FBG_DEFS_SVH

// ****************************************
// Geometry
// ****************************************
`define FBG_ADDR_W 18
`define FBG_DATA_W 8
`define FBG_BOOT_TAG 4'hf
`define FBG_BOOT_MSB 17
`define FBG_BOOT_LSB 14

// ****************************************
// Synchronised pin vector layout
// ****************************************
`define FBG_PIN_SUPPLY_OK 0
`define FBG_PIN_WP_N 1
`define FBG_PIN_BOOT_UNLOCK 2
`define FBG_PIN_PD_N 3
`define FBG_PIN_OE_N 4
`define FBG_PIN_WE_N 5
`define FBG_PIN_CS_N 6
`define FBG_PIN_DQ 7
`define FBG_PIN_ADDR 15
`define FBG_PIN_W 33

// ****************************************
// Command codes
// ****************************************
`define FBG_CMD_READ_ARRAY 8'hff
`define FBG_CMD_READ_STATUS 8'h70
`define FBG_CMD_CLEAR_STATUS 8'h50
`define FBG_CMD_PROGRAM 8'h40
`define FBG_CMD_ERASE 8'h20
`define FBG_CMD_CONFIRM 8'hd0

// ****************************************
// Status bits
// ****************************************
`define FBG_ST_READY 7
`define FBG_ST_ERASE_ERR 5
`define FBG_ST_PROG_ERR 4
`define FBG_ST_SUPPLY_LOW 3

// ****************************************
// Timing
// ****************************************
`define FBG_CLK_PERIOD_NS 100
`define FBG_PROG_TIME_NS 10000
`define FBG_ERASE_TIME_NS 300000
`define FBG_PROG_CYC ((`FBG_PROG_TIME_NS + `FBG_CLK_PERIOD_NS - 1) / `FBG_CLK_PERIOD_NS)
`define FBG_ERASE_CYC ((`FBG_ERASE_TIME_NS + `FBG_CLK_PERIOD_NS - 1) / `FBG_CLK_PERIOD_NS)
`define FBG_CNT_W 12

`endif

// ---- design/fbg_pkg.sv ----
// Types for the flash bus glue device front end
`default_nettype none
`include "fbg_defs.svh"

package fbg_pkg;

	typedef enum logic [1:0] {
		FBG_IDLE = 2'b00,
		FBG_PROG_SETUP = 2'b01,
		FBG_ERASE_SETUP = 2'b10,
		FBG_BUSY = 2'b11
	} fbg_phase_t;

	typedef enum logic {
		FBG_READ_ARRAY = 1'b0,
		FBG_READ_STATUS = 1'b1
	} fbg_mode_t;

	typedef struct packed {
		logic [`FBG_PIN_W-1:0] s1;
		logic [`FBG_PIN_W-1:0] s2;
		logic cs_p_n;
		logic we_p_n;
		logic wr_act;
		logic ctrl_we;
		logic [`FBG_ADDR_W-1:0] wr_addr;
		logic [`FBG_DATA_W-1:0] wr_data;
		fbg_phase_t phase;
		fbg_mode_t mode;
		logic [`FBG_CNT_W-1:0] cnt;
		logic err_prog;
		logic err_erase;
		logic err_supply;
		logic dq_oe;
		logic [`FBG_DATA_W-1:0] dq_out;
		logic [`FBG_ADDR_W-1:0] arr_addr;
		logic [`FBG_DATA_W-1:0] arr_wdata;
		logic arr_prog;
		logic arr_erase;
		logic busy;
		logic locked;
	} fbg_state_t;

endpackage

`default_nettype wire

// ---- design/fbg_flash_front.sv ----
// Flash command front end: strobes, write protection, sequencer start
`default_nettype none
`include "fbg_defs.svh"

module fbg_flash_front (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic chip_sel_n,
	input wire logic write_n,
	input wire logic out_en_n,
	input wire logic powerdown_unlock_n,
	input wire logic boot_unlock_high,
	input wire logic write_protect_n,
	input wire logic program_supply_ok,
	input wire logic [`FBG_ADDR_W-1:0] addr,
	input wire logic [`FBG_DATA_W-1:0] dq_in,
	input wire logic [`FBG_DATA_W-1:0] array_rdata,
	output logic [`FBG_DATA_W-1:0] dq_out,
	output logic dq_oe,
	output logic [`FBG_ADDR_W-1:0] array_addr,
	output logic [`FBG_DATA_W-1:0] array_wdata,
	output logic array_prog,
	output logic array_erase,
	output logic seq_busy,
	output logic boot_locked,
	output fbg_pkg::fbg_mode_t read_mode
);
	import fbg_pkg::*;

	fbg_state_t st_q;
	fbg_state_t st_d;

	logic cs_n;
	logic we_n;
	logic oe_n;
	logic pd_n;
	logic supply_ok;
	logic unlocked;
	logic [`FBG_ADDR_W-1:0] pin_addr;
	logic [`FBG_DATA_W-1:0] pin_dq;

	// ****************************************
	// Pin fields after the second sync stage
	// ****************************************
	assign cs_n = st_q.s2[`FBG_PIN_CS_N];
	assign we_n = st_q.s2[`FBG_PIN_WE_N];
	assign oe_n = st_q.s2[`FBG_PIN_OE_N];
	assign pd_n = st_q.s2[`FBG_PIN_PD_N];
	assign supply_ok = st_q.s2[`FBG_PIN_SUPPLY_OK];
	assign unlocked = st_q.s2[`FBG_PIN_BOOT_UNLOCK] | st_q.s2[`FBG_PIN_WP_N];
	assign pin_addr = st_q.s2[`FBG_PIN_ADDR +: `FBG_ADDR_W];
	assign pin_dq = st_q.s2[`FBG_PIN_DQ +: `FBG_DATA_W];

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic ctrl_off;
		logic commit;
		logic boot_hit;
		logic [`FBG_DATA_W-1:0] status;
		ctrl_off = 1'b0;
		commit = 1'b0;
		boot_hit = 1'b0;
		status = '0;
		st_d = st_q;
		st_d.s1 = {addr, dq_in, chip_sel_n, write_n, out_en_n, powerdown_unlock_n,
			boot_unlock_high, write_protect_n, program_supply_ok};
		st_d.s2 = st_q.s1;
		st_d.cs_p_n = cs_n;
		st_d.we_p_n = we_n;
		st_d.arr_prog = 1'b0;
		st_d.arr_erase = 1'b0;
		st_d.locked = ~unlocked;

		// Write cycle needs both strobes; the first one asserted owns it
		if (!st_q.wr_act) begin
			if (!cs_n && !we_n) begin
				st_d.wr_act = 1'b1;
				st_d.ctrl_we = ~st_q.we_p_n | st_q.cs_p_n;
				st_d.wr_addr = pin_addr;
				st_d.wr_data = pin_dq;
			end
		end else begin
			ctrl_off = st_q.ctrl_we ? we_n : cs_n;
			if (ctrl_off) begin
				st_d.wr_act = 1'b0;
				commit = 1'b1;
			end else begin
				st_d.wr_data = pin_dq;
			end
		end

		boot_hit = st_q.wr_addr[`FBG_BOOT_MSB:`FBG_BOOT_LSB] == `FBG_BOOT_TAG;

		// Command interpreter; busy sequencer ignores new writes
		case (st_q.phase)
			FBG_IDLE: begin
				if (commit) begin
					case (st_q.wr_data)
						`FBG_CMD_PROGRAM: begin
							st_d.phase = FBG_PROG_SETUP;
						end
						`FBG_CMD_ERASE: begin
							st_d.phase = FBG_ERASE_SETUP;
						end
						`FBG_CMD_READ_STATUS: begin
							st_d.mode = FBG_READ_STATUS;
						end
						`FBG_CMD_CLEAR_STATUS: begin
							st_d.err_prog = 1'b0;
							st_d.err_erase = 1'b0;
							st_d.err_supply = 1'b0;
						end
						`FBG_CMD_READ_ARRAY: begin
							st_d.mode = FBG_READ_ARRAY;
						end
						default: begin
							st_d.mode = st_q.mode;
						end
					endcase
				end
			end
			FBG_PROG_SETUP, FBG_ERASE_SETUP: begin
				if (commit) begin
					st_d.mode = FBG_READ_STATUS;
					st_d.phase = FBG_IDLE;
					if (st_q.phase == FBG_ERASE_SETUP
						&& st_q.wr_data != `FBG_CMD_CONFIRM) begin
						st_d.err_prog = 1'b1;
						st_d.err_erase = 1'b1;
					end else if (!supply_ok) begin
						st_d.err_supply = 1'b1;
						st_d.err_prog = st_q.phase == FBG_PROG_SETUP;
						st_d.err_erase = st_q.phase == FBG_ERASE_SETUP;
					end else if (boot_hit && st_q.locked) begin
						st_d.err_prog = st_q.phase == FBG_PROG_SETUP;
						st_d.err_erase = st_q.phase == FBG_ERASE_SETUP;
					end else begin
						st_d.phase = FBG_BUSY;
						st_d.arr_addr = st_q.wr_addr;
						st_d.arr_wdata = st_q.wr_data;
						st_d.arr_prog = st_q.phase == FBG_PROG_SETUP;
						st_d.arr_erase = st_q.phase == FBG_ERASE_SETUP;
						st_d.cnt = (st_q.phase == FBG_PROG_SETUP)
							? `FBG_CNT_W'(`FBG_PROG_CYC - 1)
							: `FBG_CNT_W'(`FBG_ERASE_CYC - 1);
					end
				end
			end
			FBG_BUSY: begin
				if (st_q.cnt == '0) begin
					st_d.phase = FBG_IDLE;
				end else begin
					st_d.cnt = st_q.cnt - `FBG_CNT_W'(1);
				end
			end
			default: begin
				st_d.phase = FBG_IDLE;
			end
		endcase
		st_d.busy = st_d.phase == FBG_BUSY;

		// Reads: array path stays live even with the supply low
		if (st_d.phase != FBG_BUSY) begin
			st_d.arr_addr = pin_addr;
		end
		status[`FBG_ST_READY] = ~st_q.busy;
		status[`FBG_ST_ERASE_ERR] = st_q.err_erase;
		status[`FBG_ST_PROG_ERR] = st_q.err_prog;
		status[`FBG_ST_SUPPLY_LOW] = st_q.err_supply;
		st_d.dq_oe = ~cs_n & ~oe_n & we_n & pd_n;
		st_d.dq_out = (st_q.mode == FBG_READ_ARRAY) ? array_rdata : status;

		// Power-down drops everything and wakes up reading the array
		if (!pd_n) begin
			st_d.phase = FBG_IDLE;
			st_d.mode = FBG_READ_ARRAY;
			st_d.wr_act = 1'b0;
			st_d.busy = 1'b0;
			st_d.arr_prog = 1'b0;
			st_d.arr_erase = 1'b0;
			st_d.err_prog = 1'b0;
			st_d.err_erase = 1'b0;
			st_d.err_supply = 1'b0;
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign dq_out = st_q.dq_out;
	assign dq_oe = st_q.dq_oe;
	assign array_addr = st_q.arr_addr;
	assign array_wdata = st_q.arr_wdata;
	assign array_prog = st_q.arr_prog;
	assign array_erase = st_q.arr_erase;
	assign seq_busy = st_q.busy;
	assign boot_locked = st_q.locked;
	assign read_mode = st_q.mode;

	// ****************************************
	// Checks
	// ****************************************
	a_supply_gates_ops: assert property (@(posedge core_clk) disable iff (rst)
		(array_prog || array_erase) |-> $past(st_q.s2[`FBG_PIN_SUPPLY_OK]))
		else $error("program or erase started with supply low");
	a_no_select_drive: assert property (@(posedge core_clk) disable iff (rst)
		st_q.s2[`FBG_PIN_CS_N] |=> !dq_oe)
		else $error("data driven while deselected");
	a_capture_first_addr: assert property (@(posedge core_clk) disable iff (rst)
		$rose(st_q.wr_act) |-> st_q.wr_addr == $past(st_q.s2[`FBG_PIN_ADDR +: `FBG_ADDR_W]))
		else $error("write address not captured at cycle start");
	a_ctrl_strobe_order: assert property (@(posedge core_clk) disable iff (rst)
		($rose(st_q.wr_act) && !st_q.ctrl_we) |-> $past(!st_q.cs_p_n && !st_q.we_p_n, 1) == 1'b0
		&& $past(!st_q.cs_p_n))
		else $error("wrong controlling strobe chosen");
	a_start_on_release: assert property (@(posedge core_clk) disable iff (rst)
		(array_prog || array_erase) |-> $past(st_q.wr_act) && !st_q.wr_act
		&& $past(st_q.ctrl_we ? st_q.s2[`FBG_PIN_WE_N] : st_q.s2[`FBG_PIN_CS_N]))
		else $error("sequencer started before strobe release");
	a_wake_read_array: assert property (@(posedge core_clk) disable iff (rst)
		!st_q.s2[`FBG_PIN_PD_N] |=> read_mode == FBG_READ_ARRAY && !seq_busy)
		else $error("power-down did not return to read array");
	a_boot_stays_locked: assert property (@(posedge core_clk) disable iff (rst)
		(array_prog || array_erase) && array_addr[`FBG_BOOT_MSB:`FBG_BOOT_LSB] == `FBG_BOOT_TAG
		|-> !$past(boot_locked))
		else $error("locked boot block altered");
	a_write_needs_strobe: assert property (@(posedge core_clk) disable iff (rst)
		$rose(st_q.wr_act) |-> $past(!st_q.s2[`FBG_PIN_WE_N]))
		else $error("write taken without write strobe");
	a_busy_holds: assert property (@(posedge core_clk) disable iff (rst)
		array_prog |-> seq_busy [*8])
		else $error("busy dropped early");

	c_program_run: cover property (@(posedge core_clk) disable iff (rst) array_prog);
	c_erase_run: cover property (@(posedge core_clk) disable iff (rst) array_erase);
	c_status_read: cover property (@(posedge core_clk) disable iff (rst)
		dq_oe && read_mode == FBG_READ_STATUS);
	c_supply_refused: cover property (@(posedge core_clk) disable iff (rst)
		$rose(st_q.err_supply));
	c_select_controls: cover property (@(posedge core_clk) disable iff (rst)
		$rose(st_q.wr_act) && !st_q.ctrl_we);

endmodule // fbg_flash_front

`default_nettype wire

// ---- bench/fbg_glue_model.sv ----
// Bus glue model: flash select, strobes, gating port bits, address swap
`default_nettype none
module fbg_glue_model (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic cyc,
	input wire logic mem_io,
	input wire logic write_or_read_qualifier,
	input wire logic [19:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic boot_runtime_select,
	input wire logic power_ok,
	input wire logic sys_reset_n,
	input wire logic port_we,
	input wire logic [1:0] port_wd,
	output logic [1:0] port_rd,
	output logic chip_sel_n,
	output logic write_n,
	output logic out_en_n,
	output logic powerdown_unlock_n,
	output logic xcvr_en,
	output logic [17:0] addr,
	output logic [7:0] dq_in
);
	logic [1:0] port_q;
	logic hit;
	// Bit 0 write enable, bit 1 shut-off; both come up harmless
	always_ff @(posedge core_clk) begin
		if (rst) begin
			port_q <= 2'h0;
		end else if (port_we) begin
			port_q <= port_wd;
		end
	end
	assign port_rd = port_q;
	assign hit = cyc && mem_io && (bus_addr[19:17] == 3'h7);
	assign chip_sel_n = ~hit;
	assign write_n = ~(hit && write_or_read_qualifier && port_q[0]);
	assign out_en_n = ~(hit && !write_or_read_qualifier);
	assign xcvr_en = hit;
	assign addr = {boot_runtime_select, bus_addr[16:0]};
	assign powerdown_unlock_n = power_ok && sys_reset_n && !port_q[1];
	// Released bus shows the inverse, never a stale copy
	assign dq_in = xcvr_en ? bus_wdata : ~bus_wdata;
endmodule // fbg_glue_model
`default_nettype wire

// ---- bench/tb_top.sv ----
// Bench: flash front end behind the glue model, against a command model
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import fbg_pkg::*;
	logic core_clk = 1'h0, rst = 1'h1, cyc = 1'h0, mem_io = 1'h1, wq = 1'h0, brs = 1'h0;
	logic pw_ok = 1'h1, sr_n = 1'h1, port_we = 1'h0, boot_unlock_high = 1'h0;
	logic write_protect_n = 1'h0, program_supply_ok = 1'h1;
	logic [1:0] port_wd = 2'h0, port_rd;
	logic [19:0] ba = 20'h0, a;
	logic [7:0] bd = 8'h0, dq_in, dq_out, array_wdata, array_rdata, d;
	logic [17:0] addr, array_addr;
	logic chip_sel_n, write_n, out_en_n, powerdown_unlock_n, xcvr, dq_oe;
	logic array_prog, array_erase, seq_busy, boot_locked;
	fbg_mode_t read_mode;
	int err_count = 0, checks_done = 0, cycles = 0, mode = 0, st = 0, pend = 0;
	logic [26:0] exp_q[$];
	logic [26:0] e_op;
	logic late = 1'h0;
	int busy_len = 0, busy_cnt = 0;
	initial forever #50 core_clk = ~core_clk;
	fbg_glue_model i_glue (.core_clk, .rst, .cyc, .mem_io, .write_or_read_qualifier(wq),
		.bus_addr(ba), .bus_wdata(bd), .boot_runtime_select(brs), .power_ok(pw_ok),
		.sys_reset_n(sr_n), .port_we, .port_wd, .port_rd, .chip_sel_n, .write_n, .out_en_n,
		.powerdown_unlock_n, .xcvr_en(xcvr), .addr, .dq_in);
	fbg_flash_front i_dut (.core_clk, .rst, .chip_sel_n, .write_n, .out_en_n,
		.powerdown_unlock_n, .boot_unlock_high, .write_protect_n, .program_supply_ok, .addr,
		.dq_in, .array_rdata, .dq_out, .dq_oe, .array_addr, .array_wdata, .array_prog,
		.array_erase, .seq_busy, .boot_locked, .read_mode);
	assign array_rdata = array_addr[7:0] ^ array_addr[15:8] ^ 8'h3c;
	// ****************************************
	// Checking helpers
	// ****************************************
	task automatic chk(string n, logic [26:0] e, logic [26:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic stop_test();
		$display("Checks %0d, errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// Sync flops plus register stage: eight cycles settle a read
	task automatic cycle(logic w, logic [19:0] x, logic [7:0] y, output logic [7:0] q);
		ba = x;
		bd = y;
		wq = w && !late;
		cyc = 1'h1;
		// Late write strobe lets chip select own the cycle
		tick(3);
		wq = w;
		tick(5);
		q = dq_out;
		chk("dq_oe", mem_io && !w, dq_oe);
		cyc = 1'h0;
		tick(6);
	endtask
	task automatic rd(logic [19:0] x);
		logic [7:0] q;
		logic [17:0] f;
		f = {brs, x[16:0]};
		cycle(1'h0, x, 8'h0, q);
		chk("mode", mode, read_mode);
		chk("rdata", mode ? 8'h80 | st : f[7:0] ^ f[15:8] ^ 8'h3c, q);
	endtask
	task automatic wr(logic [19:0] x, logic [7:0] y);
		logic [7:0] q;
		logic [17:0] f;
		logic lk;
		f = {brs, x[16:0]};
		lk = f[17:14] == 4'hf && !(boot_unlock_high || write_protect_n);
		// Expectation first: the start pulse comes before the cycle task returns
		if (port_rd[0] && mem_io) begin
			if (pend == 1) begin
				if (!program_supply_ok) st |= 8'h18;
				else if (lk) st |= 8'h10;
				else exp_q.push_back({1'h0, f, y});
				mode = 1;
				pend = 0;
			end else if (pend == 2) begin
				if (y != 8'hd0) st |= 8'h30;
				else if (!program_supply_ok) st |= 8'h28;
				else if (lk) st |= 8'h20;
				else exp_q.push_back({1'h1, f, 8'h0});
				mode = 1;
				pend = 0;
			end else begin
				case (y)
					8'h40: pend = 1;
					8'h20: pend = 2;
					8'h70: mode = 1;
					8'hff: mode = 0;
					8'h50: st = 0;
					default: ;
				endcase
			end
		end
		cycle(1'h1, x, y, q);
		for (int i = 0; i < 3100 && seq_busy !== 1'h0; i++) tick(1);
		chk("busy end", 27'h0, seq_busy);
		chk("ops left", 27'h0, 27'(exp_q.size()));
	endtask
	task automatic port(logic [1:0] v);
		port_wd = v;
		port_we = 1'h1;
		tick(1);
		port_we = 1'h0;
		chk("port", v, port_rd);
	endtask
	task automatic pdown(logic via_rst);
		if (via_rst) sr_n = 1'h0;
		else pw_ok = 1'h0;
		tick(6);
		sr_n = 1'h1;
		pw_ok = 1'h1;
		tick(6);
		mode = 0;
		st = 0;
		pend = 0;
	endtask
	// ****************************************
	// Array start pulses and hang guard
	// ****************************************
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			stop_test();
		end
		if (!rst && (array_prog === 1'h1 || array_erase === 1'h1)) begin
			if (exp_q.size() == 0) chk("stray op", 27'h0, 27'h1);
			else begin
				e_op = exp_q.pop_front();
				busy_len = e_op[26] ? 3000 : 100;
				chk("op", e_op, {array_erase, array_addr,
					array_erase ? 8'h0 : array_wdata});
			end
		end
		// Busy length per op: program and erase sequencer times
		if (!rst && seq_busy === 1'h1) busy_cnt++;
		else if (busy_cnt != 0) begin
			chk("busy len", busy_len, busy_cnt);
			busy_cnt = 0;
		end
	end
	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		void'($urandom(32'hf4cc21b7));
		tick(5);
		rst = 1'h0;
		tick(1);
		chk("reset", 27'h0, {dq_oe, array_prog, array_erase, seq_busy, read_mode, port_rd});
		tick(4);
		chk("locked", 27'h1, boot_locked);
		for (int i = 0; i < 4; i++) rd(20'he0000 | 20'($urandom & 32'h1bfff));
		a = 20'he0000 | 20'($urandom & 32'h1bfff);
		mem_io = 1'h0;
		wr(a, 8'h70);
		mem_io = 1'h1;
		rd(a);
		wr(a, 8'h70);
		rd(a);
		port(2'h1);
		for (int i = 0; i < 2; i++) begin
			d = 8'($urandom);
			wr(a, 8'h40);
			wr(a, d);
			rd(a);
		end
		program_supply_ok = 1'h0;
		wr(a, 8'h40);
		wr(a, 8'h3c);
		rd(a);
		wr(a, 8'hff);
		rd(a);
		program_supply_ok = 1'h1;
		wr(a, 8'h50);
		brs = 1'h1;
		wr(20'hfc123, 8'h40);
		wr(20'hfc123, 8'h5a);
		rd(20'hfc123);
		wr(20'hfc123, 8'h50);
		write_protect_n = 1'h1;
		tick(4);
		chk("unlocked", 27'h0, boot_locked);
		wr(20'hfc123, 8'h40);
		wr(20'hfc123, 8'ha5);
		brs = 1'h0;
		late = 1'h1;
		wr(a, 8'h20);
		wr(a, 8'hd0);
		late = 1'h0;
		wr(a, 8'h20);
		wr(a, 8'h11);
		rd(a);
		pdown(1'h0);
		rd(a);
		wr(a, 8'h70);
		pdown(1'h1);
		rd(a);
		wr(a, 8'h70);
		port(2'h3);
		tick(6);
		port(2'h1);
		tick(6);
		mode = 0;
		st = 0;
		rd(a);
		stop_test();
	end
endmodule // tb_top
`default_nettype wire
